// *** rtl/cpc_chain_crc_unit.sv ***
// Chain packet CRC unit: checks received headers and write payloads,
// and builds response headers, read payloads and their CRCs.
// Assumes framer streams on the device clock; register logic feeds words.
`timescale 1ns/10ps
module cpc_chain_crc_unit
   import cpc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxData,
   output logic             rxReady,
   output logic             hdrGood,
   output logic             hdrBad,
   output logic             payBad,
   output logic             cmdValid,
   output cpc_hdr_t         cmd,
   output logic             wrValid,
   output logic [15:0]      wrWord,
   output logic             wrCommit,
   input  wire logic [15:0] faultStatus,
   input  wire logic        wordValid,
   input  wire logic [15:0] wordData,
   output logic             wordReady,
   output logic             txValid,
   output logic [7:0]       txData,
   input  wire logic        txReady
);
   typedef enum logic [1:0] {R_HDR, R_CHKH, R_PAY, R_CHKP} cpc_rx_t;
   typedef enum logic [1:0] {T_IDLE, T_HDR, T_PAY, T_CRC} cpc_tx_t;

   // ---------------------------------------------------------------
   // Receive side
   // ---------------------------------------------------------------
   cpc_rx_t     rxState;
   cpc_rx_t     next_rxState;
   logic [5:0]  rxIdx;
   logic [5:0]  next_rxIdx;
   logic [23:0] hdrBits;
   logic [23:0] next_hdrBits;
   logic [7:0]  hiByte;
   logic [7:0]  next_hiByte;
   logic        next_rxReady;
   logic        next_hdrGood;
   logic        next_hdrBad;
   logic        next_payBad;
   logic        next_cmdValid;
   cpc_hdr_t    next_cmd;
   logic        next_wrValid;
   logic [15:0] next_wrWord;
   logic        next_wrCommit;
   logic        take;
   logic        rxInit;
   logic        rxWide;
   logic        rxBusy;
   logic [31:0] rxCrc;
   cpc_hdr_t    rxHdr;
   logic [5:0]  rxDataBytes;
   logic        startTx;
   logic        startAck;
   cpc_tx_t     txState;

   assign take = rxValid && rxReady;
   assign rxHdr = cpc_hdr_t'(hdrBits[22:0]);
   assign rxDataBytes = rxHdr.len - ((rxHdr.len == LEN_SINGLE) ? CRC16_BYTES : CRC32_BYTES);

   cpc_bit_crc rxEngine (
      .clock (clock),
      .reset (reset),
      .init  (rxInit),
      .wide  (rxWide),
      .load  (take),
      .data  (rxData),
      .busy  (rxBusy),
      .crc   (rxCrc)
   );

   always_comb begin
      next_rxState = rxState;
      next_rxIdx = rxIdx;
      next_hdrBits = hdrBits;
      next_hiByte = hiByte;
      next_hdrGood = 1'b0;
      next_hdrBad = 1'b0;
      next_payBad = 1'b0;
      next_cmdValid = 1'b0;
      next_cmd = cmd;
      next_wrValid = 1'b0;
      next_wrWord = wrWord;
      next_wrCommit = 1'b0;
      rxInit = 1'b0;
      rxWide = 1'b0;
      startTx = 1'b0;
      startAck = 1'b0;
      case (rxState)
         R_HDR: begin
            if (take) begin
               // The two CRC bytes run through the engine too; a clean
               // header leaves a zero remainder.
               if (rxIdx < HDR_CRC_IDX) begin
                  next_hdrBits = {hdrBits[15:0], rxData};
               end
               next_rxIdx = rxIdx + 6'h01;
               if (rxIdx == HDR_LAST) begin
                  next_rxState = R_CHKH;
               end
            end
         end
         R_CHKH: begin
            if (!rxBusy) begin
               if (rxCrc[15:0] != 16'h0000 || !hdrBits[23]) begin
                  next_hdrBad = 1'b1;
                  next_rxState = R_HDR;
                  rxInit = 1'b1;
               end else if (rxHdr.write && rxHdr.len != 6'h00) begin
                  next_hdrGood = 1'b1;
                  next_rxState = R_PAY;
                  rxInit = 1'b1;
                  rxWide = rxHdr.len != LEN_SINGLE;
               end else if (txState == T_IDLE) begin
                  next_hdrGood = 1'b1;
                  next_cmdValid = 1'b1;
                  next_cmd = rxHdr;
                  startTx = !rxHdr.write && rxHdr.len != 6'h00;
                  next_rxState = R_HDR;
                  rxInit = 1'b1;
               end
               next_rxIdx = 6'h00;
            end
         end
         R_PAY: begin
            if (take) begin
               next_rxIdx = rxIdx + 6'h01;
               if (!rxIdx[0]) begin
                  next_hiByte = rxData;
               end else if (rxIdx < rxDataBytes) begin
                  next_wrValid = 1'b1;
                  next_wrWord = {hiByte, rxData};
               end
               if (rxIdx == rxHdr.len - 6'h01) begin
                  next_rxState = R_CHKP;
               end
            end
         end
         default: begin
            if (!rxBusy) begin
               if (rxCrc != 32'h00000000) begin
                  next_payBad = 1'b1;
                  next_rxState = R_HDR;
                  rxInit = 1'b1;
               end else if (txState == T_IDLE) begin
                  next_wrCommit = 1'b1;
                  next_cmdValid = 1'b1;
                  next_cmd = rxHdr;
                  startTx = 1'b1;
                  startAck = 1'b1;
                  next_rxState = R_HDR;
                  rxInit = 1'b1;
               end
               next_rxIdx = 6'h00;
            end
         end
      endcase
      next_rxReady = (next_rxState == R_HDR || next_rxState == R_PAY) && !take && !rxBusy;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rxState <= R_HDR;
         rxIdx <= 6'h00;
         hdrBits <= 24'h000000;
         hiByte <= 8'h00;
         rxReady <= 1'b0;
         hdrGood <= 1'b0;
         hdrBad <= 1'b0;
         payBad <= 1'b0;
         cmdValid <= 1'b0;
         cmd <= '0;
         wrValid <= 1'b0;
         wrWord <= 16'h0000;
         wrCommit <= 1'b0;
      end else begin
         rxState <= next_rxState;
         rxIdx <= next_rxIdx;
         hdrBits <= next_hdrBits;
         hiByte <= next_hiByte;
         rxReady <= next_rxReady;
         hdrGood <= next_hdrGood;
         hdrBad <= next_hdrBad;
         payBad <= next_payBad;
         cmdValid <= next_cmdValid;
         cmd <= next_cmd;
         wrValid <= next_wrValid;
         wrWord <= next_wrWord;
         wrCommit <= next_wrCommit;
      end
   end

   // ---------------------------------------------------------------
   // Transmit side
   // ---------------------------------------------------------------
   cpc_tx_t     next_txState;
   logic [5:0]  txIdx;
   logic [5:0]  next_txIdx;
   cpc_hdr_t    resp;
   cpc_hdr_t    next_resp;
   logic        needStat;
   logic        next_needStat;
   logic [7:0]  lowByte;
   logic [7:0]  next_lowByte;
   logic        next_txValid;
   logic [7:0]  next_txData;
   logic        txInit;
   logic        txWide;
   logic        txLoad;
   logic        txBusy;
   logic [31:0] txCrc;
   logic        fifoValid;
   logic [15:0] fifoData;
   logic        fifoPop;
   logic        present;
   logic        sent;
   logic [5:0]  txCrcBytes;
   logic [5:0]  txDataBytes;
   logic [31:0] crcSel;

   cpc_bit_crc txEngine (
      .clock (clock),
      .reset (reset),
      .init  (txInit),
      .wide  (txWide),
      .load  (txLoad),
      .data  (next_txData),
      .busy  (txBusy),
      .crc   (txCrc)
   );

   // Back-pressure: the register logic stalls on wordReady when the
   // serialiser waits on txReady and the buffer fills.
   cpc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) readBuffer (
      .clock    (clock),
      .reset    (reset),
      .inValid  (wordValid),
      .inData   (wordData),
      .inReady  (wordReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (fifoPop)
   );

   assign present = !txValid && !txBusy;
   assign sent = txValid && txReady;
   assign txCrcBytes = (resp.len == LEN_SINGLE) ? CRC16_BYTES : CRC32_BYTES;
   assign txDataBytes = resp.len - txCrcBytes;
   assign crcSel = (resp.len == LEN_SINGLE) ? {txCrc[15:0], 16'h0000} : txCrc;

   always_comb begin
      next_txState = txState;
      next_txIdx = txIdx;
      next_resp = resp;
      next_needStat = needStat;
      next_lowByte = lowByte;
      next_txValid = txValid;
      next_txData = txData;
      txInit = 1'b0;
      txWide = 1'b0;
      txLoad = 1'b0;
      fifoPop = 1'b0;
      case (txState)
         T_IDLE: begin
            if (startTx) begin
               next_resp = rxHdr;
               next_resp.write = 1'b0;
               next_resp.frame = rxHdr.frame + 2'h1;
               next_needStat = rxHdr.len != LEN_SINGLE && rxHdr.regAddr < FAULT_LIMIT;
               if (startAck) begin
                  next_resp.regAddr = {1'b0, ACK_CODE};
                  next_resp.len = 6'h00;
                  next_needStat = 1'b0;
               end
               txInit = 1'b1;
               next_txIdx = 6'h00;
               next_txState = T_HDR;
            end
         end
         T_HDR: begin
            if (present) begin
               next_txValid = 1'b1;
               case (txIdx[2:0])
                  3'h0: next_txData = {1'b1, resp.dev, resp.write, resp.regAddr[8]};
                  3'h1: next_txData = resp.regAddr[7:0];
                  3'h2: next_txData = {resp.len, resp.frame};
                  3'h3: next_txData = txCrc[15:8];
                  default: next_txData = txCrc[7:0];
               endcase
               txLoad = txIdx < HDR_CRC_IDX;
            end else if (sent) begin
               next_txValid = 1'b0;
               next_txIdx = txIdx + 6'h01;
               if (txIdx == HDR_LAST) begin
                  next_txIdx = 6'h00;
                  if (resp.len == 6'h00) begin
                     next_txState = T_IDLE;
                  end else begin
                     txInit = 1'b1;
                     txWide = resp.len != LEN_SINGLE;
                     next_txState = T_PAY;
                  end
               end
            end
         end
         T_PAY: begin
            if (present && txIdx[0]) begin
               next_txValid = 1'b1;
               next_txData = lowByte;
               txLoad = 1'b1;
            end else if (present && needStat) begin
               next_txValid = 1'b1;
               next_txData = faultStatus[15:8];
               next_lowByte = faultStatus[7:0];
               next_needStat = 1'b0;
               txLoad = 1'b1;
            end else if (present && fifoValid) begin
               next_txValid = 1'b1;
               next_txData = fifoData[15:8];
               next_lowByte = fifoData[7:0];
               fifoPop = 1'b1;
               txLoad = 1'b1;
            end else if (sent) begin
               next_txValid = 1'b0;
               next_txIdx = txIdx + 6'h01;
               if (txIdx == txDataBytes - 6'h01) begin
                  next_txIdx = 6'h00;
                  next_txState = T_CRC;
               end
            end
         end
         default: begin
            if (present) begin
               next_txValid = 1'b1;
               case (txIdx[1:0])
                  2'h0: next_txData = crcSel[31:24];
                  2'h1: next_txData = crcSel[23:16];
                  2'h2: next_txData = crcSel[15:8];
                  default: next_txData = crcSel[7:0];
               endcase
            end else if (sent) begin
               next_txValid = 1'b0;
               next_txIdx = txIdx + 6'h01;
               if (txIdx == txCrcBytes - 6'h01) begin
                  next_txState = T_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         txState <= T_IDLE;
         txIdx <= 6'h00;
         resp <= '0;
         needStat <= 1'b0;
         lowByte <= 8'h00;
         txValid <= 1'b0;
         txData <= 8'h00;
      end else begin
         txState <= next_txState;
         txIdx <= next_txIdx;
         resp <= next_resp;
         needStat <= next_needStat;
         lowByte <= next_lowByte;
         txValid <= next_txValid;
         txData <= next_txData;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_pay_fail;
      rxState == R_CHKP && !rxBusy && rxCrc != 32'h00000000;
   endsequence

   a_corrupt_quiet: assert property (s_pay_fail |=> (!wrCommit && !cmdValid) [*2])
      else $error("corrupt payload was acted upon");
   a_frame_plus_one: assert property (startTx |=> resp.frame == $past(rxHdr.frame) + 2'h1)
      else $error("response frame not incremented");
   a_ack_header: assert property (startTx && startAck
      |=> resp.len == 6'h00 && resp.regAddr[7:0] == ACK_CODE && !resp.write)
      else $error("acknowledge header malformed");
   a_hdr_span: assert property (take && rxState == R_HDR && rxIdx == HDR_LAST
      |=> rxState == R_CHKH ##1 rxBusy)
      else $error("header span not five bytes");
   a_crc_width: assert property (txState == T_CRC && txValid && txIdx == 6'h00
      |-> txData == ((resp.len == LEN_SINGLE) ? txCrc[15:8] : txCrc[31:24]))
      else $error("payload CRC width wrong");
endmodule

// *** rtl/cpc_pkg.sv ***
// Constants and types shared by the chain packet CRC unit.
// Assumes a single device clock and byte-wide framer streams.
package cpc_pkg;
   localparam logic [31:0] CRC_INIT    = 32'hffffffff;
   localparam logic [15:0] POLY16      = 16'h1021;
   localparam logic [31:0] POLY32      = 32'h04c11db7;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [5:0]  HDR_LAST    = 6'h04;
   localparam logic [5:0]  HDR_CRC_IDX = 6'h03;
   localparam logic [5:0]  LEN_SINGLE  = 6'h04;
   localparam logic [5:0]  CRC16_BYTES = 6'h02;
   localparam logic [5:0]  CRC32_BYTES = 6'h04;
   localparam logic [7:0]  ACK_CODE    = 8'hd2;
   localparam logic [8:0]  FAULT_LIMIT = 9'h080;
   localparam int          WORD_W      = 16;
   localparam int          FIFO_DEPTH  = 8;

   // Header fields in transmitted order, leading one excluded.
   typedef struct packed {
      logic [4:0] dev;
      logic       write;
      logic [8:0] regAddr;
      logic [5:0] len;
      logic [1:0] frame;
   } cpc_hdr_t;
endpackage

// *** rtl/cpc_bit_crc.sv ***
// Bit-serial CRC engine, one input bit per clock, most significant first.
// Assumes init and load are never asserted while a byte is still shifting.
`timescale 1ns/10ps
module cpc_bit_crc
   import cpc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        init,
   input  wire logic        wide,
   input  wire logic        load,
   input  wire logic [7:0]  data,
   output logic             busy,
   output logic [31:0]      crc
);
   logic [7:0]  shiftIn;
   logic [3:0]  bitCnt;
   logic        wideQ;
   logic [31:0] next_crc;
   logic [7:0]  next_shiftIn;
   logic [3:0]  next_bitCnt;
   logic        next_wideQ;
   logic        feedback;
   logic [31:0] stepped;

   assign busy = bitCnt != 4'h0;

   always_comb begin
      next_crc = crc;
      next_shiftIn = shiftIn;
      next_bitCnt = bitCnt;
      next_wideQ = wideQ;
      feedback = shiftIn[7] ^ (wideQ ? crc[31] : crc[15]);
      stepped = {crc[30:0], 1'b0};
      if (feedback) begin
         stepped = stepped ^ (wideQ ? POLY32 : {16'h0000, POLY16});
      end
      if (!wideQ) begin
         stepped[31:16] = 16'h0000;
      end
      if (init) begin
         next_crc = wide ? CRC_INIT : {16'h0000, CRC_INIT[15:0]};
         next_wideQ = wide;
         next_bitCnt = 4'h0;
      end else if (load) begin
         next_shiftIn = data;
         next_bitCnt = BYTE_BITS;
      end else if (busy) begin
         next_crc = stepped;
         next_shiftIn = {shiftIn[6:0], 1'b0};
         next_bitCnt = bitCnt - 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         crc <= {16'h0000, CRC_INIT[15:0]};
         shiftIn <= 8'h00;
         bitCnt <= 4'h0;
         wideQ <= 1'b0;
      end else begin
         crc <= next_crc;
         shiftIn <= next_shiftIn;
         bitCnt <= next_bitCnt;
         wideQ <= next_wideQ;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_byte;
      busy [*8] ##1 !busy;
   endsequence

   a_byte_eight: assert property (load |=> s_byte)
      else $error("byte did not take exactly eight steps");
   a_preset_ones: assert property (init |=> crc == (wideQ ? CRC_INIT : 32'h0000ffff))
      else $error("crc not preset to all ones");
   a_shift_only: assert property (busy && !init && !load && !feedback
      |=> crc == ({$past(crc[30:0]), 1'b0} & (wideQ ? 32'hffffffff : 32'h0000ffff)))
      else $error("zero feedback did not shift only");
   a_fold_short: assert property (busy && !init && !load && feedback && !wideQ
      |=> crc[15:0] == ({$past(crc[14:0]), 1'b0} ^ POLY16))
      else $error("16-bit fold wrong");
   a_fold_long: assert property (busy && !init && !load && feedback && wideQ
      |=> crc == ({$past(crc[30:0]), 1'b0} ^ POLY32))
      else $error("32-bit fold wrong");
endmodule

// *** rtl/cpc_fifo.sv ***
// Synchronous FIFO with registered ready on the filling side.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module cpc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    next_rdPtr;
   logic [AW:0]      next_count;
   logic             next_inReady;
   logic             push;
   logic             pop;

   assign outValid = count != '0;
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outReady && outValid;

   always_comb begin
      next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Ready is registered so the source never sees a combinational path.
      next_inReady = next_count != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
         inReady <= next_inReady;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule

// *** bench/cpc_host_model.sv ***
// Far-side host model: offers packet bytes and drains response bytes.
// Assumes one clock; drives on the rising edge by non-blocking assignment.
`timescale 1ns/10ps
module cpc_host_model (
   input  wire logic       clock,
   output logic            rxValid,
   output logic [7:0]      rxData,
   input  wire logic       rxReady,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   output logic            txReady
);
   initial begin
      rxValid = 1'b0;
      rxData  = 8'h00;
      txReady = 1'b0;
   end

   // A released data line shows the inverse byte, never a stale copy.
   task automatic sendByte(input logic [7:0] b);
      @(posedge clock);
      rxValid <= 1'b1;
      rxData  <= b;
      do @(negedge clock); while (rxReady !== 1'b1);
      @(posedge clock);
      rxValid <= 1'b0;
      rxData  <= ~b;
   endtask

   task automatic getByte(input int stall, output logic [7:0] b);
      repeat (stall + 1) @(posedge clock);
      txReady <= 1'b1;
      do @(negedge clock); while (txValid !== 1'b1);
      b = txData;
      @(posedge clock);
      txReady <= 1'b0;
   endtask
endmodule

// *** bench/test_chain_packet_crc_unit.sv ***
// Bench for the chain packet CRC unit: reads, writes and corrupt packets.
// Assumes the host model plays the framer and the bench the register logic.
`timescale 1ns/10ps
module test_chain_packet_crc_unit
   import cpc_pkg::*;
;
   logic        clock, reset, rxValid, rxReady, hdrGood, hdrBad, payBad;
   logic        cmdValid, wrValid, wrCommit, wordValid, wordReady, txValid, txReady;
   logic [7:0]  rxData, txData;
   logic [15:0] wrWord, faultStatus, wordData, lastWr;
   cpc_hdr_t    cmd, lastCmd;
   int          nMismatch, samplesChecked, nBad, nPay, nCmd, nCommit, nFull, nWr, nGood;

   cpc_chain_crc_unit u_dut (.clock(clock), .reset(reset), .rxValid(rxValid),
      .rxData(rxData), .rxReady(rxReady), .hdrGood(hdrGood), .hdrBad(hdrBad),
      .payBad(payBad), .cmdValid(cmdValid), .cmd(cmd), .wrValid(wrValid),
      .wrWord(wrWord), .wrCommit(wrCommit), .faultStatus(faultStatus),
      .wordValid(wordValid), .wordData(wordData), .wordReady(wordReady),
      .txValid(txValid), .txData(txData), .txReady(txReady));
   cpc_host_model u_host (.clock(clock), .rxValid(rxValid), .rxData(rxData),
      .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady));

   // --------------------------------
   // Helpers
   // --------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Pulses are counted mid-cycle, away from the edge that moves them.
   always @(negedge clock) begin
      nBad    += (hdrBad === 1'b1);
      nPay    += (payBad === 1'b1);
      nCmd    += (cmdValid === 1'b1);
      nCommit += (wrCommit === 1'b1);
      nFull   += (wordValid === 1'b1 && wordReady === 1'b0);
      nWr     += (wrValid === 1'b1);
      nGood   += (hdrGood === 1'b1);
      if (cmdValid === 1'b1) lastCmd = cmd;
      if (wrValid === 1'b1) lastWr = wrWord;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] crc32(input logic [7:0] d[$]);
      logic [31:0] c;
      c = CRC_INIT;
      foreach (d[i])
         for (int k = 7; k >= 0; k--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i][k]) ? POLY32 : 32'h0);
      return c;
   endfunction

   task automatic sendPkt(input logic [7:0] p[$]);
      foreach (p[i]) u_host.sendByte(p[i]);
   endtask

   task automatic expectTx(input logic [7:0] e[$]);
      logic [7:0] b;
      foreach (e[i]) begin
         u_host.getByte(i % 3, b);
         check("txByte", b, e[i]);
      end
   endtask

   task automatic pushWords(input logic [15:0] w[$]);
      foreach (w[i]) begin
         @(posedge clock);
         wordValid <= 1'b1;
         wordData  <= w[i];
         do @(negedge clock); while (wordReady !== 1'b1);
      end
      @(posedge clock);
      wordValid <= 1'b0;
   endtask

   // --------------------------------
   // Scenarios
   // --------------------------------
   task automatic readSingle();
      sendPkt({8'h94, 8'h40, 8'h10, 8'h77, 8'h98});
      pushWords({16'h0000});
      expectTx({8'h94, 8'h40, 8'h11, 8'h67, 8'hb9, 8'h00, 8'h00, 8'h1d, 8'h0f});
      check("cmd", lastCmd, {5'h05, 1'b0, 9'h040, 6'h04, 2'h0});
   endtask

   task automatic readMulti(input logic [7:0] h[$], r[$], input int nw, bit pre);
      logic [7:0]  d[$];
      logic [15:0] w[$];
      logic [31:0] c;
      if (pre) d = {faultStatus[15:8], faultStatus[7:0]};
      for (int i = 0; i < nw; i++) begin
         w.push_back(16'h8001 + 16'(i * 291));
         d.push_back(w[i][15:8]);
         d.push_back(w[i][7:0]);
      end
      c = crc32(d);
      r = {r, d, c[31:24], c[23:16], c[15:8], c[7:0]};
      sendPkt(h);
      fork
         pushWords(w);
         expectTx(r);
      join
   endtask

   task automatic writeCases();
      logic [7:0]  q[$];
      logic [31:0] c;
      sendPkt({8'h86, 8'h40, 8'h10, 8'h5a, 8'h9b, 8'h00, 8'h0a, 8'hbc, 8'h45});
      expectTx({8'h84, 8'hd2, 8'h01, 8'h48, 8'h62});
      check("wrWord", lastWr, 16'h000a);
      check("commits", nCommit, 1);
      // Four registers: eight data bytes closed by a 32-bit CRC.
      q = {8'h8a, 8'ha7, 8'h10, 8'ha6, 8'hdf, 8'h01, 8'h02, 8'h0e};
      c = crc32(q);
      q = {8'h86, 8'ha7, 8'h30, 8'hf7, 8'hdc, q, c[31:24], c[23:16], c[15:8], c[7:0]};
      sendPkt(q);
      expectTx({8'h84, 8'hd2, 8'h01, 8'h48, 8'h62});
      check("wrWord", lastWr, 16'h020e);
      check("wrCount", nWr, 5);
      check("cmd", lastCmd, {5'h01, 1'b1, 9'h0a7, 6'h0c, 2'h0});
      sendPkt({8'h86, 8'h40, 8'h10, 8'h5a, 8'h9b, 8'h00, 8'h0a, 8'hbc, 8'h44});
      sendPkt({8'h94, 8'h40, 8'h10, 8'h77, 8'h99});
      // Action command: zero length, so a command pulse and no response.
      sendPkt({8'hfc, 8'hc1, 8'h00, 8'h7f, 8'hca});
      repeat (14) @(negedge clock);
      check("payBad", nPay, 1);
      check("hdrBad", nBad, 1);
      check("hdrGood", nGood, 8);
      check("commits", nCommit, 2);
      check("cmds", nCmd, 7);
      check("txIdle", txValid, 1'b0);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clock);
      nMismatch++;
      results();
   end

   initial begin
      reset       = 1'b1;
      wordValid   = 1'b0;
      wordData    = 16'h0000;
      faultStatus = 16'h5a3c;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      readSingle();
      readMulti({8'h90, 8'h81, 8'h58, 8'h47, 8'hf1},
         {8'h90, 8'h81, 8'h59, 8'h57, 8'hd0}, 9, 0);
      readMulti({8'h84, 8'h60, 8'h68, 8'hcd, 8'h82},
         {8'h84, 8'h60, 8'h69, 8'hdd, 8'ha3}, 10, 1);
      readMulti({8'h88, 8'h41, 8'h90, 8'he3, 8'h23},
         {8'h88, 8'h41, 8'h91, 8'hf3, 8'h02}, 15, 1);
      check("fifoFull", nFull > 0, 1);
      writeCases();
      results();
   end
endmodule
